/* flr_flash_lock_reset.sv */
// lock bit command handling and two-step software reset of the serial flash
//
// Overview of operation
// - lock bits protect only when scheme select is 1
// - lock bits volatile, all set after reset
// - lock byte shifted out MSB first, falling edges
// - byte LSB 1 means locked, 0 unlocked
// - four-byte mode uses 32-bit addresses
// - 7Eh sets every lock bit
// - 98h clears every lock bit
// - reset sets all lock bits, clears other volatile state, aborts operations
// - 66h and 99h accepted in both modes
// - 99h resets only straight after 66h
// - reset takes 30us, commands ignored meanwhile
// - 36h with address sets one lock bit
// - 39h with address clears one lock bit
`timescale 1ns/1ps
module flr_flash_lock_reset
  import flr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // serial link pins
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  // link modes
  input wire logic quad_command_mode,
  input wire logic four_byte_mode,
  // protection configuration
  input wire logic lock_scheme_select,
  input wire logic protect_complement,
  input wire logic top_bottom_select,
  input wire logic [3:0] protect_range_bits,
  // program/erase protection check
  input wire logic pe_req,
  input wire logic [31:0] pe_addr,
  output logic pe_done,
  output logic pe_denied,
  // software reset effects
  output logic volatile_clear,
  output logic reset_busy
);
  import flr_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
  logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
  logic [3:0] io_s1_reg, io_s2_reg;

  // all pins share the same two-stage delay so data stays aligned to edges
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
      io_s1_reg <= 4'h0;
      io_s2_reg <= 4'h0;
    end
    else
    begin
      sclk_s1_reg <= link_clk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      cs_s1_reg <= cs_n;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      io_s1_reg <= io_in;
      io_s2_reg <= io_s1_reg;
    end
  end

  logic sclk_rise, sclk_fall, cs_rise, cs_low;
  assign sclk_rise = sclk_s2_reg && !sclk_s3_reg;
  assign sclk_fall = !sclk_s2_reg && sclk_s3_reg;
  assign cs_rise = cs_s2_reg && !cs_s3_reg;
  assign cs_low = !cs_s2_reg;

  // ----------------------------------------------------------------
  // command decode state
  // ----------------------------------------------------------------
  flr_state_type state_reg;
  logic [5:0] cnt_reg;
  logic [39:0] shift_reg;
  logic [7:0] opcode_reg;
  logic [31:0] addr_reg;
  logic cmd_ok_reg;
  logic rst_en_reg;
  logic [11:0] rcv_cnt_reg;

  logic [5:0] step, cnt_next, addr_end;
  logic [39:0] shift_next;
  logic take_bits, op_done, addr_done, exec, rst_start;

  assign step = quad_command_mode ? STEP_QUAD : STEP_SPI;
  assign cnt_next = cnt_reg + step;
  assign shift_next = quad_command_mode ? {shift_reg[35:0], io_s2_reg}
                                        : {shift_reg[38:0], io_s2_reg[0]};
  assign addr_end = four_byte_mode ? ADDR4_END : ADDR3_END;
  assign take_bits = sclk_rise && cs_low &&
                     (state_reg == FLR_CMD || state_reg == FLR_ADDR);
  assign op_done = take_bits && state_reg == FLR_CMD && cnt_next == OPC_END;
  assign addr_done = take_bits && state_reg == FLR_ADDR && cnt_next == addr_end;
  // nothing executes until the frame ends, so a truncated frame does nothing
  assign exec = cs_rise && cmd_ok_reg && state_reg != FLR_RECOVER;
  assign rst_start = exec && opcode_reg == OP_RESET && rst_en_reg;

  // frame sequencing; recovery swallows every frame
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state_reg <= FLR_CMD;
    else if (state_reg == FLR_RECOVER)
    begin
      if (rcv_cnt_reg == RCV_ZERO)
        state_reg <= cs_low ? FLR_WAIT : FLR_CMD;
    end
    else if (rst_start)
      state_reg <= FLR_RECOVER;
    else if (cs_rise)
      state_reg <= FLR_CMD;
    else if (op_done)
      state_reg <= (shift_next[7:0] == OP_LOCK || shift_next[7:0] == OP_UNLOCK ||
                    shift_next[7:0] == OP_RD_LOCK) ? FLR_ADDR : FLR_WAIT;
    else if (addr_done)
      state_reg <= (opcode_reg == OP_RD_LOCK) ? FLR_OUT : FLR_WAIT;
  end

  // bit counter and shifter; only the counter is cleared between frames
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_reg <= 6'h00;
      shift_reg <= 40'h00_0000_0000;
    end
    else if (!cs_low)
      cnt_reg <= 6'h00;
    else if (take_bits)
    begin
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
    end
  end

  // captured opcode, address and completeness of the frame
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      opcode_reg <= 8'h00;
      addr_reg <= 32'h0000_0000;
      cmd_ok_reg <= 1'b0;
    end
    else if (cs_rise || state_reg == FLR_RECOVER)
      cmd_ok_reg <= 1'b0;
    else if (op_done)
    begin
      opcode_reg <= shift_next[7:0];
      // global and reset opcodes are complete without an address
      cmd_ok_reg <= shift_next[7:0] == OP_GLOBAL_LOCK || shift_next[7:0] == OP_GLOBAL_UNLOCK ||
                    shift_next[7:0] == OP_RESET_EN || shift_next[7:0] == OP_RESET;
    end
    else if (addr_done)
    begin
      addr_reg <= four_byte_mode ? shift_next[31:0] : {8'h00, shift_next[23:0]};
      cmd_ok_reg <= opcode_reg != OP_RD_LOCK;
    end
  end

  // reset enable arms on 66h, any other opcode disarms it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rst_en_reg <= 1'b0;
    else if (rst_start)
      rst_en_reg <= 1'b0;
    else if (op_done && shift_next[7:0] == OP_RESET_EN)
      rst_en_reg <= 1'b1;
    else if (op_done && shift_next[7:0] != OP_RESET)
      rst_en_reg <= 1'b0;
  end

  // recovery countdown after an accepted reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rcv_cnt_reg <= RCV_ZERO;
    else if (rst_start)
      rcv_cnt_reg <= RCV_LOAD;
    else if (state_reg == FLR_RECOVER && rcv_cnt_reg != RCV_ZERO)
      rcv_cnt_reg <= rcv_cnt_reg - 12'h001;
  end

  // volatile clear pulse for status, latch, suspend, read params, wrap
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      volatile_clear <= 1'b0;
    else
      volatile_clear <= rst_start;
  end
  assign reset_busy = state_reg == FLR_RECOVER;

  // ----------------------------------------------------------------
  // lock store
  // ----------------------------------------------------------------
  logic rd_bit_a, rd_bit_b;

  flr_lock_mem u_lock_mem
  (
    .clk(clk),
    .reset_n(reset_n),
    .set_all(rst_start || (exec && opcode_reg == OP_GLOBAL_LOCK)),
    .clear_all(exec && opcode_reg == OP_GLOBAL_UNLOCK),
    .wr_en(exec && (opcode_reg == OP_LOCK || opcode_reg == OP_UNLOCK)),
    .wr_idx(flr_lock_idx(addr_reg)),
    .wr_val(opcode_reg == OP_LOCK),
    .rd_idx_a(flr_lock_idx(addr_reg)),
    .rd_bit_a(rd_bit_a),
    .rd_idx_b(flr_lock_idx(pe_addr)), // looked up in the request cycle, ready for the answer
    .rd_bit_b(rd_bit_b)
  );

  // ----------------------------------------------------------------
  // lock byte output
  // ----------------------------------------------------------------
  logic [7:0] tx_reg;
  logic tx_pend_reg, tx_load_reg, oe_reg;

  // load waits two cycles for the registered read; first falling edge is later
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_pend_reg <= 1'b0;
      tx_load_reg <= 1'b0;
    end
    else
    begin
      tx_pend_reg <= addr_done && opcode_reg == OP_RD_LOCK;
      tx_load_reg <= tx_pend_reg; // address register, then read register
    end
  end

  // byte repeats for as long as the host keeps clocking
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_reg <= 8'h00;
      io_out <= 4'h0;
      oe_reg <= 1'b0;
    end
    else if (state_reg != FLR_OUT || cs_rise)
      oe_reg <= 1'b0;
    else if (tx_load_reg)
      tx_reg <= {LOCK_PAD, rd_bit_a};
    else if (sclk_fall)
    begin
      oe_reg <= 1'b1;
      io_out <= quad_command_mode ? tx_reg[7:4] : {2'b00, tx_reg[7], 1'b0};
      tx_reg <= quad_command_mode ? {tx_reg[3:0], tx_reg[7:4]} : {tx_reg[6:0], tx_reg[7]};
    end
  end
  assign io_oe = oe_reg ? (quad_command_mode ? 4'hf : 4'h2) : 4'h0;

  // ----------------------------------------------------------------
  // program/erase protection check
  // ----------------------------------------------------------------
  logic pe_pend_reg, scheme_reg, range_hit_reg;

  // two-cycle lookup: capture, then answer from the chosen scheme
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pe_pend_reg <= 1'b0;
      scheme_reg <= 1'b0;
      range_hit_reg <= 1'b0;
      pe_done <= 1'b0;
      pe_denied <= 1'b0;
    end
    else
    begin
      pe_pend_reg <= pe_req;
      if (pe_req)
      begin
        scheme_reg <= lock_scheme_select;
        range_hit_reg <= flr_range_hit(pe_addr[24:16], protect_range_bits,
                                       top_bottom_select, protect_complement);
      end
      pe_done <= pe_pend_reg;
      if (pe_pend_reg)
        pe_denied <= scheme_reg ? rd_bit_b : range_hit_reg;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_scheme_lock_deny: assert property (@(posedge clk) disable iff (!reset_n)
    (pe_req && lock_scheme_select) ##1 rd_bit_b |=> pe_done && pe_denied)
    else $error("locked target not denied");
  a_scheme_range: assert property (@(posedge clk) disable iff (!reset_n)
    (pe_pend_reg && !scheme_reg) |=> pe_denied == $past(range_hit_reg))
    else $error("range scheme ignored");
  a_out_only_read: assert property (@(posedge clk) disable iff (!reset_n)
    (io_oe != 4'h0) |-> state_reg == FLR_OUT && opcode_reg == OP_RD_LOCK)
    else $error("output driven outside lock read");
  a_lock_byte_lsb: assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg == FLR_OUT && tx_load_reg && !cs_rise) |=> tx_reg[0] == $past(rd_bit_a)
      && tx_reg[7:1] == LOCK_PAD)
    else $error("lock byte wrong");
  a_four_byte_addr: assert property (@(posedge clk) disable iff (!reset_n)
    (take_bits && state_reg == FLR_ADDR && four_byte_mode && cnt_next == ADDR3_END)
      |=> state_reg == FLR_ADDR || cs_rise)
    else $error("address ended early in four-byte mode");
  a_quad_step: assert property (@(posedge clk) disable iff (!reset_n)
    (take_bits && quad_command_mode && !cs_rise) |=> cnt_reg == $past(cnt_reg) + STEP_QUAD)
    else $error("quad mode shift wrong");
  a_rsten_cancel: assert property (@(posedge clk) disable iff (!reset_n)
    (op_done && shift_next[7:0] != OP_RESET_EN && shift_next[7:0] != OP_RESET)
      |=> !rst_en_reg)
    else $error("reset enable survived another opcode");
  a_reset_clear: assert property (@(posedge clk) disable iff (!reset_n)
    rst_start |=> volatile_clear ##1 !volatile_clear)
    else $error("volatile clear pulse wrong");
  a_recover_hold: assert property (@(posedge clk) disable iff (!reset_n)
    rst_start |=> reset_busy[*8] ##0 rcv_cnt_reg == RCV_LOAD - 12'h007)
    else $error("recovery not held");
  a_recover_ignore: assert property (@(posedge clk) disable iff (!reset_n)
    (reset_busy && rcv_cnt_reg != RCV_ZERO) |=> reset_busy && !exec)
    else $error("command taken during recovery");
endmodule : flr_flash_lock_reset

/* flr_lock_mem.sv */
// lock package constants and the lock bit store
package flr_pkg;
  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_LOCK = 8'h36;
  localparam logic [7:0] OP_UNLOCK = 8'h39;
  localparam logic [7:0] OP_RD_LOCK = 8'h3d;
  localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7e;
  localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
  localparam logic [7:0] OP_RESET_EN = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  // ----------------------------------------------------------------
  // frame bit counts (opcode plus address)
  // ----------------------------------------------------------------
  localparam logic [5:0] OPC_END = 6'h08;
  localparam logic [5:0] ADDR3_END = 6'h20;
  localparam logic [5:0] ADDR4_END = 6'h28;
  localparam logic [5:0] STEP_SPI = 6'h01;
  localparam logic [5:0] STEP_QUAD = 6'h04;
  // ----------------------------------------------------------------
  // lock array layout: 512 blocks, bottom and top block split into 16 sectors
  // ----------------------------------------------------------------
  localparam int LOCK_DEPTH = 544;
  localparam int IDX_W = 10;
  localparam logic [8:0] LAST_BLK = 9'h1ff;
  localparam logic [9:0] NUM_BLK = 10'h200;
  localparam logic [9:0] SEC_BASE_BOT = 10'h200;
  localparam logic [9:0] SEC_BASE_TOP = 10'h210;
  localparam logic [3:0] RANGE_MAX = 4'h9;
  localparam logic [6:0] LOCK_PAD = 7'h00;
  // ----------------------------------------------------------------
  // recovery time after a software reset
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int RST_TIME_US = 30;
  localparam int RST_CYCLES = RST_TIME_US * CLK_MHZ;
  localparam logic [11:0] RCV_LOAD = 12'(RST_CYCLES - 1);
  localparam logic [11:0] RCV_ZERO = 12'h000;

  typedef enum logic [2:0]
  {
    FLR_CMD = 3'b000,
    FLR_ADDR = 3'b001,
    FLR_OUT = 3'b010,
    FLR_WAIT = 3'b011,
    FLR_RECOVER = 3'b100
  } flr_state_type;

  // map a byte address to its lock bit
  function automatic logic [IDX_W-1:0] flr_lock_idx(input logic [31:0] addr);
    logic [8:0] blk;
    blk = addr[24:16];
    if (blk == 9'h000)
      flr_lock_idx = SEC_BASE_BOT + {6'h00, addr[15:12]};
    else if (blk == LAST_BLK)
      flr_lock_idx = SEC_BASE_TOP + {6'h00, addr[15:12]};
    else
      flr_lock_idx = {1'b0, blk};
  endfunction : flr_lock_idx

  // range protection from complement, top/bottom and range bits
  function automatic logic flr_range_hit(input logic [8:0] blk, input logic [3:0] bp,
                                         input logic tb, input logic cmp);
    logic [9:0] n;
    logic hit;
    if (bp == 4'h0)
      n = 10'h000;
    else if (bp > RANGE_MAX)
      n = NUM_BLK;
    else
      n = 10'h001 << (bp - 4'h1);
    hit = tb ? ({1'b0, blk} < n) : ({1'b0, blk} >= (NUM_BLK - n));
    flr_range_hit = hit ^ cmp;
  endfunction : flr_range_hit
endpackage : flr_pkg

`timescale 1ns/1ps
module flr_lock_mem
  import flr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // writes
  input wire logic set_all,
  input wire logic clear_all,
  input wire logic wr_en,
  input wire logic [flr_pkg::IDX_W-1:0] wr_idx,
  input wire logic wr_val,
  // read ports
  input wire logic [flr_pkg::IDX_W-1:0] rd_idx_a,
  output logic rd_bit_a,
  input wire logic [flr_pkg::IDX_W-1:0] rd_idx_b,
  output logic rd_bit_b
);
  logic [LOCK_DEPTH-1:0] bits_reg;

  // volatile lock bits, all locked out of reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      bits_reg <= '1;
    else if (set_all)
      bits_reg <= '1;
    else if (clear_all)
      bits_reg <= '0;
    else if (wr_en)
      bits_reg[wr_idx] <= wr_val;
  end

  // registered reads, one port per consumer
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_bit_a <= 1'b1;
      rd_bit_b <= 1'b1;
    end
    else
    begin
      rd_bit_a <= bits_reg[rd_idx_a];
      rd_bit_b <= bits_reg[rd_idx_b];
    end
  end

  a_reset_all_locked: assert property (@(posedge clk) disable iff (!reset_n)
    !$past(reset_n) |-> &bits_reg) else $error("lock bits not all set after reset");
  a_global_lock_all: assert property (@(posedge clk) disable iff (!reset_n)
    set_all |=> &bits_reg) else $error("global lock left a bit clear");
  a_global_unlock_all: assert property (@(posedge clk) disable iff (!reset_n)
    (clear_all && !set_all) |=> ~|bits_reg) else $error("global unlock left a bit set");
endmodule : flr_lock_mem

/* flr_host_model.sv */
// host side serial controller model driving the link pins
`timescale 1ns/1ps
module flr_host_model
(
  // link pins driven by the host
  output logic link_clk,
  output logic cs_n,
  output logic [3:0] io_in,
  // device answer
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  // command width
  input wire logic quad
);
  localparam realtime HALF = 62.5;

  // ----------------------------------------------------------------
  // idle link: clock parked low outside frames
  // ----------------------------------------------------------------
  initial
  begin
    link_clk = 1'b0;
    cs_n = 1'b1;
    io_in = 4'h5;
  end

  // one frame: opcode, optional address, optional lock byte read
  task automatic xfer(input logic [7:0] op, input logic [31:0] addr, input int nb,
                      input logic rd, output logic [7:0] rb, output logic [3:0] oe);
    logic [39:0] sh;
    int w;
    // step off the device clock edge so pin changes never race its sampling
    #1;
    w = quad ? 4 : 1;
    sh = {op, 32'h0};
    rb = 8'h00;
    oe = 4'h0;
    if (nb != 0)
      sh[31:0] = addr << (32 - nb);
    cs_n = 1'b0;
    for (int i = 0; i < 8 + nb; i += w)
    begin
      io_in = quad ? sh[39:36] : {~io_in[3:1], sh[39]};
      sh = sh << w;
      #HALF link_clk = 1'b1;
      #HALF link_clk = 1'b0;
    end
    // released lines flip so a stale value cannot pass for data
    io_in = ~io_in;
    for (int i = 0; rd && i < 8; i += w)
    begin
      #HALF link_clk = 1'b1;
      // undriven lines read inverted, so a missing enable cannot pass
      rb = quad ? {rb[3:0], io_out ^ ~io_oe} : {rb[6:0], io_out[1] ^ ~io_oe[1]};
      oe = io_oe;
      #HALF link_clk = 1'b0;
      io_in = ~io_in;
    end
    #HALF cs_n = 1'b1;
    #100;
  endtask : xfer
endmodule : flr_host_model

/* flr_flash_lock_reset_test.sv */
// self-checking bench for lock commands and software reset
`timescale 1ns/1ps
module flr_flash_lock_reset_test;
  import flr_pkg::*;
  typedef struct {logic [7:0] op; logic [31:0] a; logic q; logic f; logic lk;} flr_row_type;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic link_clk, cs_n;
  logic [3:0] io_in, io_out, io_oe;
  logic quad_command_mode = 1'b0;
  logic four_byte_mode = 1'b0;
  logic lock_scheme_select = 1'b1;
  logic protect_complement = 1'b0;
  logic top_bottom_select = 1'b0;
  logic [3:0] protect_range_bits = 4'h0;
  logic pe_req = 1'b0;
  logic [31:0] pe_addr = 32'h0;
  logic pe_done, pe_denied, volatile_clear, reset_busy;
  logic [7:0] rb;
  logic [3:0] roe;
  int err_total = 0;
  int compares = 0;
  int vc_count = 0;
  int busy_cycles = 0;
  // command, address, quad, four-byte, lock bit expected afterwards
  flr_row_type rows [6] = '{
    '{8'h39, 32'h00050000, 1'b0, 1'b0, 1'b0},
    '{8'h36, 32'h00050000, 1'b1, 1'b0, 1'b1},
    '{8'h39, 32'h01fff000, 1'b0, 1'b1, 1'b0},
    '{8'h98, 32'h00001000, 1'b1, 1'b1, 1'b0},
    '{8'h7e, 32'h00123000, 1'b1, 1'b1, 1'b1},
    '{8'h39, 32'h00003000, 1'b0, 1'b0, 1'b0}};

  // ----------------------------------------------------------------
  // clock, parts and monitors
  // ----------------------------------------------------------------
  always #5 clk = ~clk;

  flr_flash_lock_reset i_dut (.clk(clk), .reset_n(reset_n), .link_clk(link_clk),
    .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .quad_command_mode(quad_command_mode), .four_byte_mode(four_byte_mode),
    .lock_scheme_select(lock_scheme_select), .protect_complement(protect_complement),
    .top_bottom_select(top_bottom_select), .protect_range_bits(protect_range_bits),
    .pe_req(pe_req), .pe_addr(pe_addr), .pe_done(pe_done), .pe_denied(pe_denied),
    .volatile_clear(volatile_clear), .reset_busy(reset_busy));

  flr_host_model i_host (.link_clk(link_clk), .cs_n(cs_n), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .quad(quad_command_mode));

  // clear pulses are one cycle wide, so count them as they pass; busy is counted per cycle
  always @(posedge clk)
  begin
    if (volatile_clear === 1'b1)
      vc_count++;
    if (reset_busy === 1'b1)
      busy_cycles++;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, s);
      err_total++;
    end
  endtask : chk

  task automatic summarize();
    if (err_total == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  task automatic mode(input logic q, input logic f);
    @(posedge clk);
    quad_command_mode <= q;
    four_byte_mode <= f;
    @(posedge clk);
  endtask : mode

  task automatic send(input logic [7:0] op, input logic [31:0] a, input logic rd);
    int nb;
    nb = (op == OP_LOCK || op == OP_UNLOCK || op == OP_RD_LOCK) ? (four_byte_mode ? 32 : 24) : 0;
    i_host.xfer(op, a, nb, rd, rb, roe);
  endtask : send

  // answer lands exactly two cycles after the request edge
  task automatic pe_chk(input logic [31:0] a, input logic e);
    @(posedge clk);
    pe_req <= 1'b1;
    pe_addr <= a;
    @(posedge clk);
    pe_req <= 1'b0;
    // done is a one-cycle pulse: look while it stands
    @(posedge clk);
    #1;
    chk("pe_done", 16'h0001, 16'(pe_done));
    chk("pe_denied", 16'(e), 16'(pe_denied));
  endtask : pe_chk

  task automatic rng(input logic [3:0] bp, input logic tbs, input logic cm,
                     input logic [31:0] a, input logic e);
    @(posedge clk);
    protect_range_bits <= bp;
    top_bottom_select <= tbs;
    protect_complement <= cm;
    pe_chk(a, e);
  endtask : rng

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int k;
    int b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk("io_oe", 16'h0000, 16'(io_oe));
    chk("reset_busy", 16'h0000, 16'(reset_busy));
    send(OP_RD_LOCK, 32'h00050000, 1'b1);
    chk("lock byte", 16'h0001, 16'(rb));
    // table rows: write then read back through the link
    foreach (rows[i])
    begin
      mode(rows[i].q, rows[i].f);
      send(rows[i].op, rows[i].a, 1'b0);
      send(OP_RD_LOCK, rows[i].a, 1'b1);
      chk("lock byte", 16'(rows[i].lk), 16'(rb));
      chk("read io_oe", rows[i].q ? 16'h000f : 16'h0002, 16'(roe));
      chk("idle io_oe", 16'h0000, 16'(io_oe));
      pe_chk(rows[i].a, rows[i].lk);
    end
    send(OP_RD_LOCK, 32'h00004000, 1'b1);
    chk("lock byte", 16'h0001, 16'(rb));
    // range scheme ignores lock bits
    @(posedge clk);
    lock_scheme_select <= 1'b0;
    rng(4'h0, 1'b1, 1'b0, 32'h00050000, 1'b0);
    rng(4'h1, 1'b1, 1'b0, 32'h00000000, 1'b1);
    rng(4'h1, 1'b1, 1'b0, 32'h00010000, 1'b0);
    rng(4'h1, 1'b1, 1'b1, 32'h00000000, 1'b0);
    rng(4'h1, 1'b0, 1'b0, 32'h01ff0000, 1'b1);
    // a command between 66h and 99h cancels the reset enable, so no reset
    mode(1'b0, 1'b0);
    send(OP_GLOBAL_UNLOCK, 32'h0, 1'b0);
    send(OP_RESET_EN, 32'h0, 1'b0);
    send(OP_RD_LOCK, 32'h00050000, 1'b1);
    send(OP_RESET, 32'h0, 1'b0);
    send(OP_RD_LOCK, 32'h00050000, 1'b1);
    chk("lock byte", 16'h0000, 16'(rb));
    chk("clear pulses", 16'h0000, 16'(vc_count));
    chk("busy cycles", 16'h0000, 16'(busy_cycles));
    for (int q = 0; q < 2; q++)
    begin
      mode(q[0], 1'b0);
      send(OP_GLOBAL_UNLOCK, 32'h0, 1'b0);
      send(OP_RESET_EN, 32'h0, 1'b0);
      b0 = busy_cycles;
      send(OP_RESET, 32'h0, 1'b0);
      send(OP_GLOBAL_UNLOCK, 32'h0, 1'b0);
      for (k = 0; k < 4000 && reset_busy !== 1'b0; k++)
        @(posedge clk);
      if (k == 4000)
      begin
        err_total++;
        summarize();
      end
      chk("busy cycles", 16'h0bb8, 16'(busy_cycles - b0));
      chk("clear pulses", 16'(q + 1), 16'(vc_count));
      send(OP_RD_LOCK, 32'h00050000, 1'b1);
      chk("lock byte", 16'h0001, 16'(rb));
    end
    summarize();
  end
endmodule : flr_flash_lock_reset_test
